// ==== include/mem_option_defines.svh ====
`ifndef MEM_OPTION_DEFINES_SVH
`define MEM_OPTION_DEFINES_SVH

// Register address, bit 0 and bit 7 of the bus address are not decoded.
`define OPT_REG_ADDR 8'h06
`define OPT_ADDR_MASK 8'h7e
`define OPT_RESET 8'h00

// Field positions of the option register.
`define OPT_PRESCALE_LSB 0
`define OPT_PRESCALE_MSB 3
`define OPT_STATIC_BIT 4
`define OPT_COLW_LSB 5
`define OPT_COLW_MSB 6
`define OPT_PARITY_BIT 7

// Refresh interval is base minus step times the prescale count.
`define REFRESH_BASE 10'h200
`define REFRESH_STEP_SHIFT 5

// Column address widths per code.
`define COLW_CODE00 4'ha
`define COLW_CODE01 4'h9
`define COLW_CODE10 4'h8
`define COLW_CODE11 4'h6

`endif

// ==== include/mem_option_pkg.sv ====
package mem_option_pkg;

	typedef struct packed {
		logic parity_enable;
		logic [1:0] column_width_code;
		logic static_mode;
		logic [3:0] refresh_prescale;
	} option_s;

	typedef struct packed {
		logic [7:0] data;
		logic ale;
		logic cs_n;
		logic wr_n;
		logic rd_n;
	} bus_in_s;

	typedef struct packed {
		option_s option;
		logic [7:0] addr;
		logic wr_seen;
		logic [7:0] ad_out;
		logic ad_oe_n;
		logic [9:0] refresh_count;
		logic refresh_pending;
		logic [3:0] column_width;
		logic parity_line;
		logic parity_error;
	} state_s;

endpackage

// ==== src/memory_option_and_refresh_timer.sv ====
`timescale 1ns/10ps
`include "mem_option_defines.svh"

module memory_option_and_refresh_timer (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire mem_option_pkg::bus_in_s bus_i,
	output logic [7:0] ad_o,
	output logic ad_oe_n_o,
	input wire logic refresh_ack_i,
	input wire logic [7:0] mem_wr_data_i,
	input wire logic [7:0] mem_rd_data_i,
	input wire logic memory_parity_line_i,
	input wire logic mem_rd_valid_i,
	output logic refresh_req_o,
	output logic static_mode_o,
	output logic [3:0] column_width_o,
	output logic memory_parity_enable_o,
	output logic memory_parity_line_o,
	output logic parity_error_o,
	output mem_option_pkg::option_s option_o
);
	import mem_option_pkg::*;

	state_s state_reg;
	state_s state_next;
	logic addr_hit;
	logic wr_active;
	logic wr_strobe;
	logic rd_active;
	logic [9:0] interval;
	logic expiry;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	// address six decode
	assign addr_hit = (state_reg.addr & `OPT_ADDR_MASK) == (`OPT_REG_ADDR & `OPT_ADDR_MASK);
	assign wr_active = !bus_i.cs_n && !bus_i.wr_n;
	assign wr_strobe = wr_active && !state_reg.wr_seen && addr_hit;
	assign rd_active = !bus_i.cs_n && !bus_i.rd_n && addr_hit;

	// ---------------------------------------------------------------
	// Refresh interval
	// ---------------------------------------------------------------
	// interval from prescale count
	assign interval = `REFRESH_BASE - {1'b0, state_reg.option.refresh_prescale, 5'h00};
	assign expiry = state_reg.refresh_count == 10'h000;

	always_comb begin
		state_next = state_reg;
		state_next.wr_seen = wr_active;
		if (bus_i.ale) begin
			state_next.addr = bus_i.data;
		end
		if (wr_strobe) begin
			state_next.option = option_s'(bus_i.data);
		end
		state_next.ad_out = rd_active ? 8'(state_reg.option) : 8'h00;
		state_next.ad_oe_n = !rd_active;
		if (expiry || state_reg.option.static_mode) begin
			state_next.refresh_count = interval - 10'h001;
		end else begin
			state_next.refresh_count = state_reg.refresh_count - 10'h001;
		end
		// The set wins over an acknowledge in the same cycle.
		if (refresh_ack_i) begin
			state_next.refresh_pending = 1'b0;
		end
		if (state_reg.option.static_mode) begin
			state_next.refresh_pending = 1'b0;
		end else if (expiry) begin
			state_next.refresh_pending = 1'b1;
		end
		if (state_reg.option.static_mode) begin
			state_next.column_width = `COLW_CODE00;
		end else begin
			unique case (state_reg.option.column_width_code)
				2'h0: state_next.column_width = `COLW_CODE00;
				2'h1: state_next.column_width = `COLW_CODE01;
				2'h2: state_next.column_width = `COLW_CODE10;
				2'h3: state_next.column_width = `COLW_CODE11;
			endcase
		end
		state_next.parity_line = state_reg.option.parity_enable ? ~^mem_wr_data_i : 1'b1;
		state_next.parity_error = state_reg.option.parity_enable && mem_rd_valid_i &&
			!(^{mem_rd_data_i, memory_parity_line_i});
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg.option <= option_s'(`OPT_RESET);
			state_reg.addr <= 8'h00;
			state_reg.wr_seen <= 1'b0;
			state_reg.ad_out <= 8'h00;
			state_reg.ad_oe_n <= 1'b1;
			state_reg.refresh_count <= `REFRESH_BASE - 10'h001;
			state_reg.refresh_pending <= 1'b0;
			state_reg.column_width <= `COLW_CODE00;
			state_reg.parity_line <= 1'b1;
			state_reg.parity_error <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign ad_o = state_reg.ad_out;
	assign ad_oe_n_o = state_reg.ad_oe_n;
	assign refresh_req_o = state_reg.refresh_pending;
	assign static_mode_o = state_reg.option.static_mode;
	assign column_width_o = state_reg.column_width;
	assign memory_parity_enable_o = state_reg.option.parity_enable;
	assign memory_parity_line_o = state_reg.parity_line;
	assign parity_error_o = state_reg.parity_error;
	assign option_o = state_reg.option;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	a_write_stores_value: assert property (
		wr_strobe |=> 8'(state_reg.option) == $past(bus_i.data))
		else $error("option write not stored");

	a_read_returns_cfg: assert property (
		rd_active && !wr_strobe |=> !ad_oe_n_o && ad_o == 8'(state_reg.option))
		else $error("option read wrong");

	a_field_layout: assert property (
		wr_strobe |=> static_mode_o == $past(bus_i.data[`OPT_STATIC_BIT])
		&& memory_parity_enable_o == $past(bus_i.data[`OPT_PARITY_BIT]))
		else $error("option fields misplaced");

	a_interval_reload: assert property (
		expiry && !state_reg.option.static_mode && !wr_strobe
		|=> state_reg.refresh_count == 10'(512 - 32 * state_reg.option.refresh_prescale) - 10'h001)
		else $error("refresh reload wrong");

	a_interval_all_codes: assert property (
		interval == 10'(512 - 32 * int'(state_reg.option.refresh_prescale)))
		else $error("interval formula wrong");

	a_expiry_raises_req: assert property (
		expiry && !state_reg.option.static_mode |=> refresh_req_o)
		else $error("refresh request missing");

	a_static_no_refresh: assert property (
		static_mode_o ##1 static_mode_o |-> !refresh_req_o)
		else $error("refresh in static mode");

	a_static_width_ten: assert property (
		static_mode_o ##1 static_mode_o |-> column_width_o == 4'ha)
		else $error("static width not ten");

	a_parity_off_high: assert property (
		!memory_parity_enable_o ##1 !memory_parity_enable_o |-> memory_parity_line_o)
		else $error("parity line not high");

	a_parity_odd_gen: assert property (
		memory_parity_enable_o && !wr_strobe |=> ^{$past(mem_wr_data_i), memory_parity_line_o})
		else $error("parity not odd");

	a_parity_check_odd: assert property (
		memory_parity_enable_o && mem_rd_valid_i
		|=> parity_error_o == !$past(^{mem_rd_data_i, memory_parity_line_i}))
		else $error("parity check wrong");

	a_parity_check_off: assert property (
		!memory_parity_enable_o |=> !parity_error_o)
		else $error("parity error while disabled");

	a_width_per_code: assert property (
		!static_mode_o
		|=> column_width_o == ($past(option_o.column_width_code) == 2'h3 ? 4'h6
			: 4'ha - {2'h0, $past(option_o.column_width_code)}))
		else $error("column width wrong");

	a_ack_clears_req: assert property (
		refresh_ack_i && !expiry |=> !refresh_req_o)
		else $error("acknowledge did not clear request");

	a_req_holds: assert property (
		refresh_req_o && !refresh_ack_i && !static_mode_o |=> refresh_req_o)
		else $error("request dropped without acknowledge");

	a_count_down: assert property (
		!expiry && !static_mode_o
		|=> state_reg.refresh_count == $past(state_reg.refresh_count) - 10'h001)
		else $error("refresh timer did not count");

	a_static_count_hold: assert property (
		static_mode_o && !wr_strobe |=> state_reg.refresh_count == interval - 10'h001)
		else $error("timer not held in static mode");

	a_read_released: assert property (
		!rd_active |=> ad_oe_n_o && ad_o == 8'h00)
		else $error("bus driven without read");

	a_write_once: assert property (
		wr_active && state_reg.wr_seen |=> $stable(option_o))
		else $error("held write stored twice");

	a_other_addr_ignored: assert property (
		!addr_hit |=> $stable(option_o))
		else $error("write to other address stored");
endmodule

// ==== verification/refresh_arbiter_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Arbiter side that grants refresh after a delay.
// ----------------------------------------
module refresh_arbiter_model #(parameter int DELAY = 2) (
	input wire logic clk_i,
	input wire logic req_i,
	output logic ack_o
);
	int held = 0;
	always @(negedge clk_i) begin
		held = req_i ? held + 1 : 0;
		ack_o <= req_i && held > DELAY;
	end
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	import mem_option_pkg::*;
	logic sys_clk_i = 0, resetn_i = 0, ack, mrv = 0, mpl = 0;
	bus_in_s bus = '{8'h00, 1'b0, 1'b1, 1'b1, 1'b1};
	logic [7:0] ad, mwd = 0, mrd = 0;
	logic oe_n, req, stat, pe, pl, perr;
	logic [3:0] cw;
	logic [3:0] cwt [4] = '{4'ha, 4'h9, 4'h8, 4'h6};
	option_s opt;
	int err_count = 0, checks_done = 0, cyc = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	memory_option_and_refresh_timer uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus_i(bus),
		.ad_o(ad), .ad_oe_n_o(oe_n), .refresh_ack_i(ack), .mem_wr_data_i(mwd), .mem_rd_data_i(mrd),
		.memory_parity_line_i(mpl), .mem_rd_valid_i(mrv), .refresh_req_o(req), .static_mode_o(stat),
		.column_width_o(cw), .memory_parity_enable_o(pe), .memory_parity_line_o(pl),
		.parity_error_o(perr), .option_o(opt));
	refresh_arbiter_model arb (.clk_i(sys_clk_i), .req_i(req), .ack_o(ack));
	// ----------------------------------------
	// Checking, closing and bus tasks.
	// ----------------------------------------
	task chk(input logic [9:0] seen, input logic [9:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 25000) begin
			err_count++;
			end_sim;
		end
	end
	task do_reset;
		@(negedge sys_clk_i) resetn_i = 0;
		repeat (3) @(negedge sys_clk_i);
		resetn_i = 1;
		chk(opt, 8'h00);
		chk(cw, 4'ha);
		chk(pl, 1'b1);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_i) bus = '{a, 1'b1, 1'b1, 1'b1, 1'b1};
		@(negedge sys_clk_i) bus = '{d, 1'b0, 1'b0, 1'b0, 1'b1};
		@(negedge sys_clk_i) bus = '{~d, 1'b0, 1'b1, 1'b1, 1'b1};
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d, output logic oe);
		@(negedge sys_clk_i) bus = '{a, 1'b1, 1'b1, 1'b1, 1'b1};
		@(negedge sys_clk_i) bus = '{~a, 1'b0, 1'b0, 1'b1, 1'b0};
		repeat (2) @(negedge sys_clk_i);
		d = ad;
		oe = oe_n;
		bus = '{a, 1'b0, 1'b1, 1'b1, 1'b1};
	endtask
	// Counts cycles from one seen request to the next.
	task wait_req(output int n);
		n = 0;
		while (req === 1'b1 && n < 1000) begin
			@(negedge sys_clk_i);
			n++;
		end
		while (req !== 1'b1 && n < 1000) begin
			@(negedge sys_clk_i);
			n++;
		end
	endtask
	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	task t_code(input logic [3:0] c);
		logic [7:0] v, d;
		logic oe, e;
		int n;
		v = {c[0], c[2:1], 1'b0, c};
		do_reset;
		wr(8'h06, v);
		rd(8'h07, d, oe);
		chk(d, v);
		chk(oe, 1'b0);
		chk(opt, v);
		chk({pe, stat, cw}, {c[0], 1'b0, cwt[c[2:1]]});
		mwd = {4'h0, c};
		mrd = mwd;
		mpl = ^c;
		mrv = 1;
		@(negedge sys_clk_i) mpl = ~^c;
		e = perr;
		@(negedge sys_clk_i) mrv = 0;
		chk(e, c[0]);
		chk(perr, 1'b0);
		chk(pl, c[0] ? ~^c : 1'b1);
		wait_req(n);
		wait_req(n);
		chk(n[9:0], 10'h200 - 10'd32 * c);
		$display("refresh code %0d done", c);
	endtask
	task t_static;
		logic [7:0] d;
		logic oe, e;
		do_reset;
		wr(8'h86, 8'hf0);
		wr(8'h08, 8'h55);
		rd(8'h08, d, oe);
		chk(oe, 1'b1);
		rd(8'h06, d, oe);
		chk(d, 8'hf0);
		chk({stat, cw}, 5'h1a);
		e = 0;
		repeat (700) @(negedge sys_clk_i) e |= req;
		chk(e, 1'b0);
		$display("static mode done");
	endtask
	initial begin
		for (int i = 0; i < 16; i++)
			t_code(i[3:0]);
		t_static;
		end_sim;
	end
endmodule
